// ### hdl/timer_pkg.sv
package timer_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0]  TIMER_RUN_FLAG_REGISTER_IDX    = 10'h088;
  localparam logic [9:0]  TIMER_MODE_REGISTER_IDX    = 10'h089;
  localparam logic [9:0]  TL0_IDX     = 10'h08A;
  localparam logic [9:0]  TL1_IDX     = 10'h08B;
  localparam logic [9:0]  TH0_IDX     = 10'h08C;
  localparam logic [9:0]  TH1_IDX     = 10'h08D;
  localparam logic [9:0]  TIMER_CLOCK_CONTROL_IDX   = 10'h08E;
  localparam logic [9:0]  CFG_IDX     = 10'h090;
  localparam int          ADDR_W      = 12;

  // clock control fields
  localparam int          CK_SCA_LO   = 0;
  localparam int          CK_T0M      = 2;
  localparam int          CK_T1M      = 3;
  localparam int          CK_C_LOW    = 4;
  localparam int          CK_C_HIGH   = 5;
  localparam int          CK_D_LOW    = 6;
  localparam int          CK_D_HIGH   = 7;
  localparam logic [7:0]  TIMER_CLOCK_CONTROL_RESET = 8'h00;

  // run/flag register fields
  localparam int          TC_TR0      = 4;
  localparam int          TC_TF0      = 5;
  localparam int          TC_TR1      = 6;
  localparam int          TC_TF1      = 7;

  // mode register fields (second timer sits 4 bits up)
  localparam int          TM_MODE     = 0;
  localparam int          TM_CT       = 2;
  localparam int          TM_GATE     = 3;
  localparam int          TM_T1       = 4;

  // gate polarity / irq enable register fields
  localparam int          CF_POL0     = 0;
  localparam int          CF_POL1     = 1;
  localparam int          CF_IE0      = 2;
  localparam int          CF_IE1      = 3;

  // modes and prescaler selects
  localparam logic [1:0]  MODE_13     = 2'h0;
  localparam logic [1:0]  MODE_16     = 2'h1;
  localparam logic [1:0]  MODE_RELOAD = 2'h2;
  localparam logic [1:0]  MODE_SPLIT  = 2'h3;
  localparam logic [1:0]  SCA_DIV4    = 2'h1;
  localparam logic [1:0]  SCA_DIV48   = 2'h2;
  localparam logic [1:0]  SCA_EXT     = 2'h3;
  localparam logic [5:0]  DIV12_LAST  = 6'(12 - 1);
  localparam logic [5:0]  DIV4_LAST   = 6'(4 - 1);
  localparam logic [5:0]  DIV48_LAST  = 6'(48 - 1);
  localparam logic [2:0]  EXT8_LAST   = 3'(8 - 1);
  localparam logic [12:0] MAX13       = 13'h1FFF;

  // synchroniser lanes
  localparam int          SY_EV0      = 0;
  localparam int          SY_EV1      = 1;
  localparam int          SY_G0       = 2;
  localparam int          SY_G1       = 3;
  localparam int          SY_EXT      = 4;

  typedef struct packed {
    logic ext_clock_pin;
    logic second_gate_input;
    logic first_gate_input;
    logic second_event_pin;
    logic first_event_pin;
  } pins_type;

  typedef struct packed {
    logic timer_d_high_byte_clock_pick;
    logic timer_d_low_byte_clock_pick;
    logic timer_c_high_byte_clock_pick;
    logic timer_c_low_byte_clock_pick;
  } byte_pick_type;

  typedef struct packed {
    logic [7:0] timer_clock_control;
    logic [7:0] timer_mode_register;
    logic       tf1;
    logic       tr1;
    logic       tf0;
    logic       tr0;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [3:0] cfg;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [1:0] ev_prev;
    logic       ext_prev;
    logic [5:0] presc_cnt;
    logic [2:0] ext_cnt;
    logic [1:0] ovf_pulse;
    logic       ack;
    logic [7:0] rdata;
  } state_type;

endpackage : timer_pkg

// ### hdl/dual_counter_timer.sv
`timescale 1ns/1ps
module dual_counter_timer (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire timer_pkg::pins_type          pins,
  input  wire logic                         first_isr_ack,
  input  wire logic                         second_isr_ack,
  output logic                              first_irq,
  output logic                              second_irq,
  output logic                              first_overflow_pulse,
  output logic                              second_overflow_pulse,
  output timer_pkg::byte_pick_type          byte_picks
);
  import timer_pkg::*;

  state_type   state_reg;
  state_type   state_next;
  logic [1:0]  fall;
  logic        presc_tick;
  logic        run0;
  logic        run1;
  logic        src0;
  logic        src_int;
  logic        split;
  logic        hit;
  logic        bus_wr;
  logic [9:0]  idx;
  logic [7:0]  rd_mux;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0]  lo_split;
  logic [8:0]  hi_split;
  logic        ov0;
  logic        ov1;
  logic        ovh;

  // one increment in the chosen mode; result is {overflow, high, low}
  function automatic logic [16:0] count_step(input logic [1:0] m, input logic [7:0] h, input logic [7:0] l);
    logic [12:0] c13;
    begin
      c13 = {h, l[4:0]} + 13'h0001;
      case (m)
        // upper low bits just ride along
        MODE_13:     count_step = {({h, l[4:0]} == MAX13), c13[12:5], l[7:5], c13[4:0]};
        MODE_16:     count_step = {({h, l} == 16'hFFFF), h + {7'h00, (l == 8'hFF)}, l + 8'h01};
        // high byte is the reload and stays put
        MODE_RELOAD: count_step = (l == 8'hFF) ? {1'b1, h, h} : {1'b0, h, l + 8'h01};
        default:     count_step = {1'b0, h, l};
      endcase
    end
  endfunction : count_step

  // bus decode; pready never waits beyond the one access cycle
  assign idx     = paddr[ADDR_W-1:2];
  assign pready  = psel & penable & state_reg.ack;
  assign bus_wr  = pready & pwrite;
  assign pslverr = pready & ~hit;
  assign prdata  = {24'h000000, state_reg.rdata};

  // requests leave only through their enable bits
  assign first_irq             = state_reg.tf0 & state_reg.cfg[CF_IE0];
  assign second_irq            = state_reg.tf1 & state_reg.cfg[CF_IE1];
  // overflow pulses independent of the flags
  assign first_overflow_pulse  = state_reg.ovf_pulse[0];
  assign second_overflow_pulse = state_reg.ovf_pulse[1];
  // byte clock picks handed straight to the reload timers
  assign byte_picks = state_reg.timer_clock_control[CK_D_HIGH:CK_C_LOW];

  // read mux; reserved bits read zero
  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    case (idx)
      TIMER_RUN_FLAG_REGISTER_IDX:  rd_mux = {state_reg.tf1, state_reg.tr1, state_reg.tf0, state_reg.tr0, 4'h0};
      TIMER_MODE_REGISTER_IDX:  rd_mux = state_reg.timer_mode_register;
      TL0_IDX:   rd_mux = state_reg.tl0;
      TL1_IDX:   rd_mux = state_reg.tl1;
      TH0_IDX:   rd_mux = state_reg.th0;
      TH1_IDX:   rd_mux = state_reg.th1;
      TIMER_CLOCK_CONTROL_IDX: rd_mux = state_reg.timer_clock_control;
      CFG_IDX:   rd_mux = {4'h0, state_reg.cfg};
      default:   hit = 1'b0;
    endcase
  end

  // all timer behaviour in one next-state process
  always_comb
  begin
    state_next = state_reg;
    // pins pass two flops before anything looks at them
    state_next.sync1   = pins;
    state_next.sync2   = state_reg.sync1;
    state_next.ev_prev = state_reg.sync2[SY_EV1:SY_EV0];
    state_next.ext_prev = state_reg.sync2[SY_EXT];
    // falling edge on a synchronised event pin
    fall = state_reg.ev_prev & ~state_reg.sync2[SY_EV1:SY_EV0];

    // prescaler, external source counted on its rising edges
    presc_tick = 1'b0;
    if (state_reg.timer_clock_control[CK_SCA_LO+1:CK_SCA_LO] == SCA_EXT)
    begin
      state_next.presc_cnt = 6'h00;
      if (state_reg.sync2[SY_EXT] & ~state_reg.ext_prev)
      begin
        presc_tick         = (state_reg.ext_cnt == EXT8_LAST);
        state_next.ext_cnt = state_reg.ext_cnt + 3'h1;
      end
    end
    else
    begin
      case (state_reg.timer_clock_control[CK_SCA_LO+1:CK_SCA_LO])
        SCA_DIV4:  presc_tick = (state_reg.presc_cnt >= DIV4_LAST);
        SCA_DIV48: presc_tick = (state_reg.presc_cnt >= DIV48_LAST);
        default:   presc_tick = (state_reg.presc_cnt >= DIV12_LAST);
      endcase
      state_next.presc_cnt = presc_tick ? 6'h00 : state_reg.presc_cnt + 6'h01;
      state_next.ext_cnt   = 3'h0;
    end

    // run bit and optional gate, polarity from the config register
    run0 = state_reg.tr0 & (~state_reg.timer_mode_register[TM_GATE] | (state_reg.sync2[SY_G0] == state_reg.cfg[CF_POL0]));
    // second timer uses its own gate, input and polarity
    run1 = state_reg.tr1 & (~state_reg.timer_mode_register[TM_T1+TM_GATE]
           | (state_reg.sync2[SY_G1] == state_reg.cfg[CF_POL1]));
    // first timer clock pick, ignored while counting events
    src0    = state_reg.timer_mode_register[TM_CT] ? fall[0] : (state_reg.timer_clock_control[CK_T0M] | presc_tick);
    // second timer clock pick drives its internal source
    src_int = state_reg.timer_clock_control[CK_T1M] | presc_tick;
    // mode 3 on the first timer means split
    split   = (state_reg.timer_mode_register[1:0] == MODE_SPLIT);

    // count only moves on an increment, never on a run-bit write
    step0    = count_step(state_reg.timer_mode_register[1:0], state_reg.th0, state_reg.tl0);
    step1    = count_step(state_reg.timer_mode_register[5:4], state_reg.th1, state_reg.tl1);
    lo_split = {1'b0, state_reg.tl0} + 9'h001;
    hi_split = {1'b0, state_reg.th0} + 9'h001;
    ov0 = 1'b0;
    ov1 = 1'b0;
    ovh = 1'b0;
    if (split)
    begin
      // low byte keeps the first timer's controls
      if (run0 & src0)
      begin
        state_next.tl0 = lo_split[7:0];
        ov0            = lo_split[8];
      end
      // high byte on internal clock, second run bit
      if (state_reg.tr1 & src_int)
      begin
        state_next.th0 = hi_split[7:0];
        ovh            = hi_split[8];
      end
    end
    else if (run0 & src0)
    begin
      {ov0, state_next.th0, state_next.tl0} = step0;
    end

    // during split no pins, no gate, no flag; mode 3 halts it
    if (state_reg.timer_mode_register[5:4] != MODE_SPLIT)
    begin
      if (split ? src_int
                : (run1 & (state_reg.timer_mode_register[TM_T1+TM_CT] ? fall[1] : src_int)))
      begin
        {ov1, state_next.th1, state_next.tl1} = step1;
      end
    end
    state_next.ovf_pulse = {ov1, ov0};

    // bus: capture read data at setup, act on the access edge
    if (psel & ~penable)
    begin
      state_next.ack   = 1'b1;
      state_next.rdata = rd_mux;
    end
    if (pready)
    begin
      state_next.ack = 1'b0;
    end
    if (bus_wr)
    begin
      // bytes written individually; a write beats a same-cycle count
      case (idx)
        TIMER_RUN_FLAG_REGISTER_IDX:
        begin
          state_next.tf1 = pwdata[TC_TF1];
          state_next.tr1 = pwdata[TC_TR1];
          state_next.tf0 = pwdata[TC_TF0];
          state_next.tr0 = pwdata[TC_TR0];
        end
        TIMER_MODE_REGISTER_IDX:  state_next.timer_mode_register  = pwdata[7:0];
        TL0_IDX:   state_next.tl0   = pwdata[7:0];
        TL1_IDX:   state_next.tl1   = pwdata[7:0];
        TH0_IDX:   state_next.th0   = pwdata[7:0];
        TH1_IDX:   state_next.th1   = pwdata[7:0];
        TIMER_CLOCK_CONTROL_IDX: state_next.timer_clock_control = pwdata[7:0];
        CFG_IDX:   state_next.cfg   = pwdata[3:0];
        default:   ;
      endcase
    end

    if (first_isr_ack)
    begin
      state_next.tf0 = 1'b0;
    end
    if (second_isr_ack)
    begin
      state_next.tf1 = 1'b0;
    end
    // overflow sets the flag, winning over any clear
    if (ov0)
    begin
      state_next.tf0 = 1'b1;
    end
    // split high byte owns the second flag
    if (split ? ovh : ov1)
    begin
      state_next.tf1 = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg       <= '0;
      state_reg.timer_clock_control <= TIMER_CLOCK_CONTROL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // the gap only counts while the ratio stays at four; a ratio change ends the check quietly
  sequence div4_gap_s;
    (!presc_tick && state_reg.timer_clock_control[1:0] == SCA_DIV4) [*3];
  endsequence

  flag_on_wrap_a: assert property (state_reg.ovf_pulse[0] |-> state_reg.tf0)
    else $error("first overflow pulse without flag");

  reload_copy_a: assert property ((state_reg.timer_mode_register[1:0] == MODE_RELOAD) && state_reg.ovf_pulse[0]
      && !$past(bus_wr) |-> state_reg.tl0 == state_reg.th0)
    else $error("reload did not copy high byte");

  idle_hold_a: assert property (!state_reg.tr0 && !split && !bus_wr
      |=> $stable({state_reg.th0, state_reg.tl0}))
    else $error("stopped timer moved");

  irq_follow_a: assert property ($rose(state_reg.tf0) && state_reg.cfg[CF_IE0] |-> first_irq)
    else $error("enabled flag gave no request");

  div4_space_a: assert property (presc_tick && state_reg.timer_clock_control[1:0] == SCA_DIV4
      && $stable(state_reg.timer_clock_control) ##1 div4_gap_s |=> state_reg.presc_cnt == DIV4_LAST)
    else $error("divide by four spacing wrong");

  event_count_a: assert property (state_reg.timer_mode_register[3:0] == 4'h5 && state_reg.tr0 && fall[0] && !bus_wr
      |=> {state_reg.th0, state_reg.tl0} == $past({state_reg.th0, state_reg.tl0}) + 16'h0001)
    else $error("event edge not counted");

  split_high_a: assert property (split && state_reg.tr1 && state_reg.timer_clock_control[CK_T1M]
      && state_reg.th0 == 8'hFF && !bus_wr |=> state_reg.tf1)
    else $error("split high byte overflow missed");

  second_stop_a: assert property (state_reg.timer_mode_register[5:4] == MODE_SPLIT && !bus_wr
      |=> $stable({state_reg.th1, state_reg.tl1}))
    else $error("mode three second timer moved");

  isr_clear_a: assert property (first_isr_ack && !state_next.ovf_pulse[0] && !bus_wr
      |=> !state_reg.tf0)
    else $error("vectoring did not clear flag");

endmodule : dual_counter_timer

// ### tb/pin_source.sv
`timescale 1ns/1ps
module pin_source (
  input  wire logic           ref_clk,
  output timer_pkg::pins_type pins
);
  import timer_pkg::*;
  logic [1:0] ext_div = 2'h0;
  // event pins idle high, gates start inactive
  initial pins = 5'h03;
  // free-running external clock, eight system clocks a period
  always @(posedge ref_clk)
  begin
    ext_div <= ext_div + 2'h1;
    if (ext_div == 2'h3) pins.ext_clock_pin <= ~pins.ext_clock_pin;
  end
  task automatic events(input int t, input int n);
    repeat (n)
    begin
      if (t == 0) pins.first_event_pin <= 1'b0; else pins.second_event_pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
      if (t == 0) pins.first_event_pin <= 1'b1; else pins.second_event_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask : events
  task automatic gate(input int t, input logic v);
    if (t == 0) pins.first_gate_input <= v; else pins.second_gate_input <= v;
  endtask : gate
endmodule : pin_source

// ### tb/dual_counter_timer_with_prescaler_bench.sv
`timescale 1ns/1ps
`define chk(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module dual_counter_timer_with_prescaler_bench;
  import timer_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, seed;
  logic        pready, pslverr, err, ack0 = 1'b0, ack1 = 1'b0;
  logic [1:0]  irq, ovf;
  logic [7:0]  rd, v, r;
  logic [9:0]  tl, th;
  pins_type    pins;
  byte_pick_type byte_picks;
  int          mismatches = 0, n_compared = 0, cycles = 0, n;
  int          divs [4] = '{12, 4, 48, 64};
  always #50 ref_clk = ~ref_clk;
  pin_source pm (.ref_clk(ref_clk), .pins(pins));
  dual_counter_timer dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .first_isr_ack(ack0), .second_isr_ack(ack1), .first_irq(irq[0]), .second_irq(irq[1]),
    .first_overflow_pulse(ovf[0]), .second_overflow_pulse(ovf[1]), .byte_picks(byte_picks));
  // one apb transfer; waits on pready, idle cycle after so psel never toggles in one step
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= {idx, 2'h0}; pwdata <= {24'h0, d};
    @(posedge ref_clk); penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata[7:0]; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rchk(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, idx, 8'h0);
    `chk(rd & m, e)
  endtask : rchk
  // bounded wait for an overflow pulse of timer t
  task automatic wait_ovf(input int t);
    int k;
    k = 0;
    while (ovf[t] !== 1'b1 && k < 3000)
    begin
      @(posedge ref_clk); k++;
    end
    `chk(k < 3000, 1'b1)
  endtask : wait_ovf
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // hang guard, well above the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++; give_verdict();
    end
  end
  initial
  begin
    seed = 32'h2DAA0221;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(TIMER_CLOCK_CONTROL_IDX, 8'hFF, TIMER_CLOCK_CONTROL_RESET);
    v = $random(seed);
    wr(TIMER_CLOCK_CONTROL_IDX, v);
    rchk(TIMER_CLOCK_CONTROL_IDX, 8'hFF, v);
    `chk(byte_picks, v[7:4])
    bus(1'b0, 10'h3FF, 8'h0);
    `chk(err, 1'b1)
    $display("registers done");
    // prescaler ratios; run window of six ticks, +-1 for phase
    for (int i = 0; i < 4; i++)
    begin
      wr(TIMER_CLOCK_CONTROL_IDX, 8'(i)); wr(TIMER_MODE_REGISTER_IDX, MODE_16); wr(TL0_IDX, 8'h0); wr(TH0_IDX, 8'h0);
      wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << TC_TR0));
      repeat (divs[i] * 6) @(posedge ref_clk);
      wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'h0); bus(1'b0, TL0_IDX, 8'h0);
      `chk(rd >= 8'h5 && rd <= 8'h7, 1'b1)
    end
    $display("prescaler done");
    // overflow in modes 13, 16 and reload for both timers
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3; m++)
      begin
        tl = t ? TL1_IDX : TL0_IDX; th = t ? TH1_IDX : TH0_IDX; r = $random(seed) & 8'h7F;
        wr(TIMER_CLOCK_CONTROL_IDX, 8'h0C); wr(CFG_IDX, 8'h0C); wr(TIMER_MODE_REGISTER_IDX, 8'(m << (4 * t)));
        wr(th, m == 2 ? r : 8'hFF); wr(tl, m == 2 ? 8'hFF : 8'hF8);
        wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << (t ? TC_TR1 : TC_TR0)));
        wait_ovf(t);
        `chk(irq[t], 1'b1)
        wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << (t ? TC_TF1 : TC_TF0)));
        rchk(th, 8'hFF, m == 2 ? r : 8'h0);
        rchk(TIMER_RUN_FLAG_REGISTER_IDX, 8'hF0, 8'(1 << (t ? TC_TF1 : TC_TF0)));
        wr(CFG_IDX, 8'h0);
        `chk(irq[t], 1'b0)
        if (t == 0)
        begin
          ack0 <= 1'b1; @(posedge ref_clk); ack0 <= 1'b0; @(posedge ref_clk);
        end
        else wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'h0);
        rchk(TIMER_RUN_FLAG_REGISTER_IDX, 8'hF0, 8'h0);
      end
    $display("overflow done");
    // falling edges on each event pin
    for (int t = 0; t < 2; t++)
    begin
      tl = t ? TL1_IDX : TL0_IDX;
      wr(TIMER_MODE_REGISTER_IDX, 8'(((1 << TM_CT) | MODE_16) << (4 * t))); wr(tl, 8'h0);
      wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << (t ? TC_TR1 : TC_TR0)));
      n = 1 + ($random(seed) & 7);
      pm.events(t, n);
      repeat (8) @(posedge ref_clk);
      rchk(tl, 8'hFF, 8'(n));
      wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'h0);
    end
    $display("events done");
    // gate input active high holds the count until raised
    wr(CFG_IDX, 8'(1 << CF_POL0)); wr(TIMER_CLOCK_CONTROL_IDX, 8'h04);
    wr(TIMER_MODE_REGISTER_IDX, 8'((1 << TM_GATE) | MODE_16)); wr(TL0_IDX, 8'h0); wr(TH0_IDX, 8'h0);
    wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << TC_TR0));
    repeat (20) @(posedge ref_clk);
    rchk(TL0_IDX, 8'hFF, 8'h0);
    pm.gate(0, 1'b1);
    repeat (20) @(posedge ref_clk);
    bus(1'b0, TL0_IDX, 8'h0);
    `chk(rd >= 8'd15, 1'b1)
    wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'h0); pm.gate(0, 1'b0);
    $display("gate done");
    // split: high byte runs on second run bit, sets second flag; second timer stopped
    wr(TIMER_CLOCK_CONTROL_IDX, 8'h08); wr(TIMER_MODE_REGISTER_IDX, 8'h33); wr(TH0_IDX, 8'hF0); wr(TL1_IDX, 8'h0);
    wr(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << TC_TR1));
    // split high byte sets the second flag but not the second timer's pulse
    repeat (30) @(posedge ref_clk);
    rchk(TIMER_RUN_FLAG_REGISTER_IDX, 8'(1 << TC_TF1), 8'(1 << TC_TF1));
    rchk(TL1_IDX, 8'hFF, 8'h0);
    $display("split done");
    give_verdict();
  end
endmodule : dual_counter_timer_with_prescaler_bench
